// >>> bench/eqrl_regs_props.sv
// checker for the egress rate-limit register bank
// assumes it is bound to eqrl_regs and sees only its ports
module eqrl_props
	import eqrl_pkg::*;
#(
	parameter int NUM_PORTS   = 3,
	parameter int NUM_QUEUES  = 4,
	parameter int TICK_CYCLES = 40,
	parameter int CREDIT_W    = 10
) (
	input wire logic                             clock,
	input wire logic                             arst_n,
	input wire eqrl_apb_req_t                    apb_req,
	input wire eqrl_apb_rsp_t                    apb_rsp,
	input wire logic [1:0]                       if_mode_pin,
	input wire logic                             pkg_pin,
	input wire logic [NUM_PORTS*NUM_QUEUES-1:0]  q_valid,
	input wire logic [NUM_PORTS*NUM_QUEUES-1:0]  q_ready,
	input wire logic [NUM_PORTS-1:0]             fc_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_wr;
		apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
	endsequence
	a_ready_next: assert property (
		s_setup |=> apb_rsp.pready) else $error("no ready after setup");
	a_ready_access: assert property (
		apb_rsp.pready |-> apb_req.psel && apb_req.penable) else $error("stray ready");
	a_rdata_width: assert property (
		apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0) else $error("upper bits set");
	a_rdata_idle: assert property (
		!apb_rsp.pready |-> apb_rsp.prdata == 32'h0) else $error("data outside access");
	a_err_misalign: assert property (
		s_setup ##0 apb_req.paddr[1:0] != 2'h0 |=> apb_rsp.pslverr) else $error("no error");
	a_err_mapped: assert property (
		s_setup ##0 (apb_req.paddr >= 12'h268 && apb_req.paddr <= 12'h2a8
		&& apb_req.paddr[1:0] == 2'h0) |=> !apb_rsp.pslverr) else $error("false error");
	a_err_zero: assert property (
		apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0) else $error("bad error");
	a_fc_update: assert property (
		s_wr ##0 apb_req.paddr == 12'h268 |-> ##2 fc_enable[0] == $past(apb_req.pwdata[7], 2))
		else $error("enable not updated");
	a_fc_hold: assert property (
		!(apb_req.psel && apb_req.penable && apb_req.pwrite) |=> ##1 $stable(fc_enable))
		else $error("enable moved");
	a_rst_outputs: assert property (
		$rose(arst_n) |-> &q_ready && fc_enable == '0 && !apb_rsp.pready)
		else $error("outputs not idle after reset");
endmodule // eqrl_props

bind eqrl_regs eqrl_props #(.NUM_PORTS(NUM_PORTS), .NUM_QUEUES(NUM_QUEUES),
	.TICK_CYCLES(TICK_CYCLES), .CREDIT_W(CREDIT_W)) u_eqrl_props (.clock(clock),
	.arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .if_mode_pin(if_mode_pin),
	.pkg_pin(pkg_pin), .q_valid(q_valid), .q_ready(q_ready), .fc_enable(fc_enable));

// >>> bench/eqrl_regs_tb.sv
// self-checking bench for the egress rate-limit register bank
// assumes eqrl_regs with a short shaper tick; the bench drives apb and straps
module eqrl_regs_tb;
	import eqrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 4;
	logic          clock;
	logic          arst_n;
	eqrl_apb_req_t req;
	eqrl_apb_rsp_t rsp;
	logic [1:0]    if_mode_pin;
	logic          pkg_pin;
	logic [11:0]   q_valid;
	logic [11:0]   q_ready;
	logic [2:0]    fc_enable;
	int            errors;
	int            comparisons;
	logic [31:0]   rd;
	logic          err;
	logic [7:0]    mode_val [3] = '{8'h43, 8'h53, 8'h41};
	int            n0;
	int            n1;

	eqrl_regs #(.TICK_CYCLES(TICK)) u_eqrl_regs (.clock(clock), .arst_n(arst_n),
		.apb_req(req), .apb_rsp(rsp), .if_mode_pin(if_mode_pin), .pkg_pin(pkg_pin),
		.q_valid(q_valid), .q_ready(q_ready), .fc_enable(fc_enable));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clock);
		req.penable <= 1'b1;
		// pready is seen as it stood at each edge; only the watchdog ends a hang
		@(posedge clock);
		while (rsp.pready !== 1'b1)
			@(posedge clock);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		check(32'(err), 32'(e));
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic e);
		apb(1'b0, a, 32'h0);
		check(rd, x);
		check(32'(err), 32'(e));
	endtask

	task automatic do_reset();
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		// straps are captured a few edges after release
		repeat (6) @(posedge clock);
	endtask

	task automatic tally_and_finish();
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		tally_and_finish();
	end

	initial begin
		errors = 0;
		comparisons = 0;
		arst_n = 1'b0;
		req = '0;
		if_mode_pin = 2'h0;
		pkg_pin = 1'b1;
		q_valid = 12'h000;
		do_reset();
		for (int i = 0; i < 12; i++)
			rd_chk(12'h268 + 12'(4 * i), 32'h0, 1'b0);
		for (int i = 0; i < 4; i++)
			rd_chk(12'h29c + 12'(4 * i), 32'h45 - 32'(16 * i), 1'b0);
		check(32'(fc_enable), 32'h0);
		for (int i = 0; i < 12; i++)
			wr(12'h268 + 12'(4 * i), 32'h10 + 32'(i) + (i % 4 == 0 && i < 8 ? 32'h80 : 32'h0), 1'b0);
		check(32'(fc_enable), 32'h3);
		for (int i = 0; i < 12; i++)
			rd_chk(12'h268 + 12'(4 * i), 32'h10 + 32'(i) + (i % 4 == 0 && i < 8 ? 32'h80 : 32'h0), 1'b0);
		wr(12'h298, 32'h00, 1'b0);
		rd_chk(12'h298, 32'h43, 1'b0);
		rd_chk(12'h000, 32'h0, 1'b1);
		wr(12'h26a, 32'h7f, 1'b1);
		rd_chk(12'h268, 32'h90, 1'b0);
		for (int m = 0; m < 3; m++) begin
			if_mode_pin <= 2'(m);
			pkg_pin <= (m == 1);
			do_reset();
			rd_chk(12'h298, 32'({mode_val[m][7], m == 1, mode_val[m][5:0]}), 1'b0);
		end
		q_valid <= 12'h006;
		wr(12'h26c, 32'h1, 1'b0);
		n0 = 0;
		n1 = 0;
		repeat (80) begin
			@(posedge clock);
			n0 += int'(q_ready[1]);
			n1 += int'(q_ready[2]);
		end
		check(32'(n1), 32'd80);
		check(32'(n0 >= 80 / TICK - 1 && n0 <= 80 / TICK + 1), 32'h1);
		tally_and_finish();
	end
endmodule // eqrl_regs_tb

// >>> rtl/eqrl_cfg.svh
// register offsets, field positions, reset values and timing counts of the
// egress rate-limit bank; definitions only, included by the package and the top
`ifndef EQRL_CFG_SVH
`define EQRL_CFG_SVH

// register indices; byte address on the bus is four times the index
`define EQRL_IDX_P1_Q0        8'h9a
`define EQRL_IDX_P2_Q0        8'h9e
`define EQRL_IDX_P3_Q0        8'ha2
`define EQRL_IDX_PORT_STRIDE  8'h04
`define EQRL_IDX_P1_Q1        8'h9b
`define EQRL_IDX_P1_Q2        8'h9c
`define EQRL_IDX_P1_Q3        8'h9d
`define EQRL_IDX_P2_Q1        8'h9f
`define EQRL_IDX_P2_Q2        8'ha0
`define EQRL_IDX_P2_Q3        8'ha1
`define EQRL_IDX_P3_Q1        8'ha3
`define EQRL_IDX_P3_Q2        8'ha4
`define EQRL_IDX_P3_Q3        8'ha5
`define EQRL_IDX_MODE_IND     8'ha6
`define EQRL_IDX_BUF_RSV_Q3   8'ha7
`define EQRL_IDX_BUF_RSV_Q2   8'ha8
`define EQRL_IDX_BUF_RSV_Q1   8'ha9
`define EQRL_IDX_BUF_RSV_Q0   8'haa

// field positions
`define EQRL_RATE_MSB         6
`define EQRL_RATE_LSB         0
`define EQRL_FC_EN_BIT        7
`define EQRL_MODE_PKG_BIT     6

// reset values
`define EQRL_RATE_RST         8'h00
`define EQRL_MODE_A_VAL       8'h43
`define EQRL_MODE_B_VAL       8'h53
`define EQRL_MODE_C_VAL       8'h41
`define EQRL_BUF_RSV_Q3_VAL   8'h45
`define EQRL_BUF_RSV_Q2_VAL   8'h35
`define EQRL_BUF_RSV_Q1_VAL   8'h25
`define EQRL_BUF_RSV_Q0_VAL   8'h15

// timing: shaper credit interval
`define EQRL_CLK_PERIOD_NS    25
`define EQRL_TICK_NS          1000
`define EQRL_TICK_CYCLES      ((`EQRL_TICK_NS + `EQRL_CLK_PERIOD_NS - 1) / `EQRL_CLK_PERIOD_NS)

`endif

// >>> rtl/eqrl_pkg.sv
// types shared by the egress rate-limit bank and its shaper
// assumes a 12-bit byte address and 32-bit data on the register bus
`include "eqrl_cfg.svh"

package eqrl_pkg;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} eqrl_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} eqrl_apb_rsp_t;

	typedef enum logic [1:0] {
		interface_mode_a,
		interface_mode_b,
		interface_mode_c
	} eqrl_if_mode_t;

	typedef enum logic [1:0] {
		eqrl_strap_wait,
		eqrl_strap_fill,
		eqrl_strap_take,
		eqrl_strap_held
	} eqrl_strap_st_t;

endpackage : eqrl_pkg

// >>> rtl/eqrl_regs.sv
// egress rate-limit register bank for three ports of four queues each,
// with mode indicator and reserved buffer registers, on an APB slave
// assumes one clock, straps on pins, and queue byte offers on this clock
//
// The APB slave port was chosen for this implementation.
`include "eqrl_cfg.svh"

module eqrl_regs
	import eqrl_pkg::*;
#(
	parameter int NUM_PORTS   = 3,
	parameter int NUM_QUEUES  = 4,
	parameter int TICK_CYCLES = `EQRL_TICK_CYCLES,
	parameter int CREDIT_W    = 10
) (
	input  wire logic                           clock,
	input  wire logic                           arst_n,
	input  wire eqrl_apb_req_t                  apb_req,
	output eqrl_apb_rsp_t                       apb_rsp,
	input  wire logic [1:0]                     if_mode_pin,
	input  wire logic                           pkg_pin,
	input  wire logic [NUM_PORTS*NUM_QUEUES-1:0] q_valid,
	output logic [NUM_PORTS*NUM_QUEUES-1:0]     q_ready,
	output logic [NUM_PORTS-1:0]                fc_enable
);

	localparam int NQ = NUM_PORTS * NUM_QUEUES;

	// the map and the read mux are laid out for three ports of four queues
	if (NUM_PORTS != 3 || NUM_QUEUES != 4) begin : g_bad_map
		$error("eqrl_regs: register map serves three ports of four queues");
	end

	// the credit-interval counter is sixteen bits wide
	if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
		$error("eqrl_regs: TICK_CYCLES out of range");
	end

	// a bucket no wider than the rate code could bank at most one full refill
	if (CREDIT_W <= `EQRL_RATE_MSB - `EQRL_RATE_LSB + 1) begin : g_bad_credit
		$error("eqrl_regs: CREDIT_W must exceed the rate field width");
	end

	// register index of a port's queue field
	function automatic logic [7:0] field_index(input int p, input int q);
		field_index = 8'(`EQRL_IDX_P1_Q0 + p * `EQRL_IDX_PORT_STRIDE + q);
	endfunction

	// word-aligned address inside the map window
	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = (a[1:0] == 2'b00) && (a[11:10] == 2'b00);
	endfunction

	function automatic logic [7:0] mode_value(input eqrl_if_mode_t m, input logic pkg);
		logic [7:0] v;
		v = `EQRL_MODE_A_VAL;
		case (m)
			interface_mode_a: v = `EQRL_MODE_A_VAL;
			interface_mode_b: v = `EQRL_MODE_B_VAL;
			interface_mode_c: v = `EQRL_MODE_C_VAL;
			default:          v = `EQRL_MODE_A_VAL;
		endcase
		v[`EQRL_MODE_PKG_BIT] = pkg;
		mode_value = v;
	endfunction

	// storage
	logic [7:0]     rate_q [NUM_PORTS][NUM_QUEUES];
	logic [1:0]     mode_s1_q;
	logic [1:0]     mode_s2_q;
	logic           pkg_s1_q;
	logic           pkg_s2_q;
	eqrl_strap_st_t strap_st_q;
	logic [7:0]     mode_ind_q;
	logic [15:0]    tick_cnt_q;
	logic           tick_q;
	eqrl_apb_rsp_t  rsp_q;

	// bus decode
	logic       setup;
	logic       wr_commit;
	logic [7:0] idx;
	logic       hit;
	logic [7:0] rd_byte;
	logic [NQ-1:0] field_sel;
	logic [NQ-1:0] field_we;

	assign setup     = apb_req.psel & ~apb_req.penable;
	assign wr_commit = apb_req.psel & apb_req.penable & rsp_q.pready & apb_req.pwrite;
	assign idx       = apb_req.paddr[9:2];

	// one select per queue field, shared by the read mux and the write strobes
	always_comb begin
		field_sel = '0;
		if (addr_ok(apb_req.paddr)) begin
			for (int g = 0; g < NQ; g++) begin
				if (idx == field_index(g / NUM_QUEUES, g % NUM_QUEUES))
					field_sel[g] = 1'b1;
			end
		end
	end

	// at most one strobe is high, so a write cannot reach a neighbouring field
	assign field_we = field_sel & {NQ{wr_commit}};

	always_comb begin
		hit     = 1'b0;
		rd_byte = 8'h00;
		if (addr_ok(apb_req.paddr)) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				for (int q = 0; q < NUM_QUEUES; q++) begin
					if (field_sel[p * NUM_QUEUES + q]) begin
						hit     = 1'b1;
						rd_byte = rate_q[p][q];
					end
				end
			end
			case (idx)
				`EQRL_IDX_MODE_IND: begin
					hit     = 1'b1;
					rd_byte = mode_ind_q;
				end
				`EQRL_IDX_BUF_RSV_Q3: begin
					hit     = 1'b1;
					rd_byte = `EQRL_BUF_RSV_Q3_VAL;
				end
				`EQRL_IDX_BUF_RSV_Q2: begin
					hit     = 1'b1;
					rd_byte = `EQRL_BUF_RSV_Q2_VAL;
				end
				`EQRL_IDX_BUF_RSV_Q1: begin
					hit     = 1'b1;
					rd_byte = `EQRL_BUF_RSV_Q1_VAL;
				end
				`EQRL_IDX_BUF_RSV_Q0: begin
					hit     = 1'b1;
					rd_byte = `EQRL_BUF_RSV_Q0_VAL;
				end
				default: begin
				end
			endcase
		end
	end

	// answer is registered in the setup cycle so the access phase never waits
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rsp_q <= '0;
		end else if (setup) begin
			rsp_q.prdata  <= {24'h000000, rd_byte};
			rsp_q.pready  <= 1'b1;
			rsp_q.pslverr <= ~hit;
		end else begin
			rsp_q.prdata  <= '0;
			rsp_q.pready  <= 1'b0;
			rsp_q.pslverr <= 1'b0;
		end
	end

	assign apb_rsp = rsp_q;

	// rate fields; each register written only by its own index
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				for (int q = 0; q < NUM_QUEUES; q++) begin
					rate_q[p][q] <= `EQRL_RATE_RST;
				end
			end
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				for (int q = 0; q < NUM_QUEUES; q++) begin
					if (field_we[p * NUM_QUEUES + q])
						rate_q[p][q] <= apb_req.pwdata[7:0];
				end
			end
		end
	end

	// bit 7 of q1-q3 is stored as written but drives nothing, so a stray
	// write there cannot disturb shaping; keeping it zero is up to software
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			fc_enable <= '0;
		else
			for (int p = 0; p < NUM_PORTS; p++)
				fc_enable[p] <= rate_q[p][0][`EQRL_FC_EN_BIT];
	end

	// strap synchronisers; first stage read only by the second
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mode_s1_q <= 2'b00;
			mode_s2_q <= 2'b00;
			pkg_s1_q  <= 1'b0;
			pkg_s2_q  <= 1'b0;
		end else begin
			mode_s1_q <= if_mode_pin;
			mode_s2_q <= mode_s1_q;
			pkg_s1_q  <= pkg_pin;
			pkg_s2_q  <= pkg_s1_q;
		end
	end

	// straps are latched once, after the synchronisers have filled; the take
	// state falls on the third edge after release, the first one at which the
	// second stage holds a pin value rather than its reset value
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strap_st_q <= eqrl_strap_wait;
		end else begin
			case (strap_st_q)
				eqrl_strap_wait: strap_st_q <= eqrl_strap_fill;
				eqrl_strap_fill: strap_st_q <= eqrl_strap_take;
				eqrl_strap_take: strap_st_q <= eqrl_strap_held;
				eqrl_strap_held: strap_st_q <= eqrl_strap_held;
				default:         strap_st_q <= eqrl_strap_wait;
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			mode_ind_q <= `EQRL_MODE_A_VAL;
		else if (strap_st_q == eqrl_strap_take)
			mode_ind_q <= mode_value(eqrl_if_mode_t'(mode_s2_q), pkg_s2_q);
	end

	// shared credit interval for every shaper
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
			tick_q     <= 1'b0;
		end
	end

	// one shaper per queue, each fed only by its own field
	for (genvar g = 0; g < NQ; g++) begin : g_shaper
		eqrl_shaper #(
			.RATE_W   (`EQRL_RATE_MSB - `EQRL_RATE_LSB + 1),
			.CREDIT_W (CREDIT_W)
		) u_shaper (
			.clock      (clock),
			.arst_n     (arst_n),
			.tick       (tick_q),
			.rate       (rate_q[g / NUM_QUEUES][g % NUM_QUEUES][`EQRL_RATE_MSB:`EQRL_RATE_LSB]),
			.byte_valid (q_valid[g]),
			.byte_ready (q_ready[g])
		);
	end

endmodule // eqrl_regs

// >>> rtl/eqrl_shaper.sv
// one egress queue shaper: a token bucket refilled by the queue's rate code
// assumes tick is a one-cycle pulse on the same clock and byte_valid comes
// from the egress datapath on the same clock
module eqrl_shaper
	import eqrl_pkg::*;
#(
	parameter int RATE_W   = 7,
	parameter int CREDIT_W = 10
) (
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic              tick,
	input  wire logic [RATE_W-1:0] rate,
	input  wire logic              byte_valid,
	output logic                   byte_ready
);

	if (CREDIT_W <= RATE_W) begin : g_bad_width
		$error("eqrl_shaper: CREDIT_W must exceed RATE_W");
	end

	localparam logic [CREDIT_W:0] CREDIT_MAX = {1'b0, {CREDIT_W{1'b1}}};

	logic [CREDIT_W-1:0] credit_q;
	logic [CREDIT_W:0]   credit_sum;
	logic [CREDIT_W-1:0] credit_d;
	logic                take;

	assign take = byte_valid & byte_ready;

	// saturate so a long idle period cannot bank an unbounded burst
	always_comb begin
		credit_sum = {1'b0, credit_q};
		if (tick)
			credit_sum = credit_sum + {{(CREDIT_W + 1 - RATE_W){1'b0}}, rate};
		if (take && credit_sum != '0)
			credit_sum = credit_sum - (CREDIT_W + 1)'(1);
		if (credit_sum > CREDIT_MAX)
			credit_d = CREDIT_MAX[CREDIT_W-1:0];
		else
			credit_d = credit_sum[CREDIT_W-1:0];
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			credit_q <= '0;
		else
			credit_q <= credit_d;
	end

	// rate code zero leaves the queue unshaped
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			byte_ready <= 1'b1;
		else
			byte_ready <= (rate == '0) || (credit_d != '0);
	end

endmodule // eqrl_shaper
